/* File: design/nco_gate_pkg.sv */
package nco_gate_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [11:0] ADDR_TX_GATING  = 12'h03f;
	localparam logic [11:0] ADDR_DP_CFG     = 12'h111;
	localparam logic [11:0] ADDR_TW_LOAD    = 12'h113;
	localparam logic [11:0] ADDR_TW_BYTE0   = 12'h114;
	localparam logic [11:0] ADDR_TW_BYTE5   = 12'h119;
	localparam logic [11:0] ADDR_FREQ_MODE  = 12'h800;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int TXG_DAC_PASS     = 7;
	localparam int TXG_DP_PASS      = 6;
	localparam int TXG_RST_PIN      = 3;
	localparam int TXG_DAC_PIN      = 2;
	localparam int TXG_DP_PIN       = 1;
	localparam int TXG_FS_PIN       = 0;
	localparam int DP_DROOP_EN      = 7;
	localparam int TW_LOAD_REQ      = 0;
	localparam int TW_LOAD_ACK      = 1;
	localparam int TW_SEL_LO        = 4;
	localparam int FM_LO            = 6;

	localparam logic [7:0] TXG_WMASK    = 8'hcf;
	localparam logic [7:0] TXG_RESET    = 8'hc0;
	localparam logic [7:0] DP_RESET     = 8'h00;
	localparam logic [7:0] TW_RESET     = 8'h00;
	localparam logic [7:0] FM_RESET     = 8'h00;
	localparam logic [1:0] FM_CONTINUOUS = 2'b00;
	localparam logic [1:0] FM_RESET_ACC  = 2'b01;
	localparam logic [2:0] SEL_MANUAL    = 3'b000;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ        = 50;
	localparam int COMMIT_MAX_NS  = 240;
	localparam int COMMIT_CYCLES  = (COMMIT_MAX_NS * CLK_MHZ) / 1000;
	localparam int RESET_TOL_CYC  = 6;
	localparam int FS_STEPS       = 16;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [11:0] addr;
		logic [7:0]  wdata;
	} reg_req_t;

	typedef struct packed {
		logic [15:0] sample;
	} sample_t;

	typedef enum logic [1:0] {
		ACK_IDLE = 2'b00,
		ACK_WAIT = 2'b01,
		ACK_DONE = 2'b11
	} ack_state_t;

endpackage

/* File: design/sample_fifo.sv */
`timescale 1ns/1ps
module sample_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;

	wire push = in_valid && in_ready;
	wire pop  = out_valid && out_ready;

	assign in_ready  = cnt_q != (AW+1)'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign out_data  = mem[rd_q];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			case ({push, pop})
				2'b10:   cnt_q <= cnt_q + 1'b1;
				2'b01:   cnt_q <= cnt_q - 1'b1;
				default: cnt_q <= cnt_q;
			endcase
		end
	end
endmodule

/* File: design/nco_update_and_tx_gating.sv */
`timescale 1ns/1ps
module nco_update_and_tx_gating
	import nco_gate_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Register port
	input  reg_req_t         reg_req,
	output logic      [7:0]  reg_rdata,
	// Pins
	input  wire logic        tx_enable_pin,
	input  wire logic        sysref,
	input  wire logic        link_fault,
	// Sample stream in
	input  wire logic        in_valid,
	output logic             in_ready,
	input  sample_t          in_sample,
	// Sample stream to DAC decoder
	output logic             dac_valid,
	input  wire logic        dac_ready,
	output sample_t          dac_sample,
	// Oscillator and current
	output logic      [47:0] phase_acc,
	output logic      [3:0]  fs_current,
	output logic             droop_active
);

	// ****************************************
	// Register state
	// ****************************************
	logic [7:0]  txg_q;
	logic [7:0]  dp_q;
	logic [7:0]  twl_q;
	logic [7:0]  fm_q;
	logic [47:0] stage_q;
	logic [47:0] tw_q;
	logic        ack_q;
	ack_state_t  ack_st_q;

	function automatic logic wr_at(input reg_req_t r, input logic [11:0] a);
		return r.valid && r.write && r.addr == a;
	endfunction

	function automatic logic [2:0] byte_idx(input logic [11:0] a);
		return 3'(a - ADDR_TW_BYTE0);
	endfunction

	wire tw_byte_wr = reg_req.valid && reg_req.write
		&& reg_req.addr >= ADDR_TW_BYTE0 && reg_req.addr <= ADDR_TW_BYTE5;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			txg_q <= TXG_RESET;
			dp_q  <= DP_RESET;
			fm_q  <= FM_RESET;
		end else begin
			if (wr_at(reg_req, ADDR_TX_GATING)) begin
				txg_q <= reg_req.wdata & TXG_WMASK;
			end
			if (wr_at(reg_req, ADDR_DP_CFG)) begin
				dp_q <= reg_req.wdata;
			end
			if (wr_at(reg_req, ADDR_FREQ_MODE)) begin
				fm_q <= reg_req.wdata;
			end
		end
	end

	// Staging holds bytes until a commit moves them to the live word
	always_ff @(posedge clk) begin
		if (!resetn) begin
			stage_q <= '0;
		end else if (tw_byte_wr) begin
			stage_q[8*byte_idx(reg_req.addr) +: 8] <= reg_req.wdata;
		end
	end

	// ****************************************
	// Commit logic
	// ****************************************
	wire [2:0] sel       = twl_q[TW_SEL_LO +: 3];
	wire       auto_mode = sel != SEL_MANUAL;
	wire       req_wr    = wr_at(reg_req, ADDR_TW_LOAD);
	wire       req_rise  = req_wr && reg_req.wdata[TW_LOAD_REQ] && !twl_q[TW_LOAD_REQ];
	// Select 1..6 names bytes 0..5; combinational so the commit is one cycle
	wire       auto_hit  = auto_mode && tw_byte_wr
		&& byte_idx(reg_req.addr) == 3'(sel - 3'd1);
	wire       commit    = (!auto_mode && req_rise) || auto_hit;

	logic [47:0] commit_word;
	always_comb begin
		commit_word = stage_q;
		if (tw_byte_wr) begin
			commit_word[8*byte_idx(reg_req.addr) +: 8] = reg_req.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			twl_q <= TW_RESET;
		end else if (req_wr) begin
			twl_q <= {1'b0, reg_req.wdata[6:4], 3'b000, reg_req.wdata[TW_LOAD_REQ]};
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			tw_q <= '0;
		end else if (commit) begin
			tw_q <= commit_word;
		end
	end

	// Ack drops on a new commit, rises two cycles after the commit
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ack_st_q <= ACK_IDLE;
			ack_q    <= 1'b0;
		end else begin
			case (ack_st_q)
				ACK_IDLE: begin
					if (commit) begin
						ack_st_q <= ACK_WAIT;
						ack_q    <= 1'b0;
					end
				end
				ACK_WAIT: begin
					ack_st_q <= ACK_DONE;
					ack_q    <= 1'b1;
				end
				ACK_DONE: begin
					if (commit) begin
						ack_st_q <= ACK_WAIT;
						ack_q    <= 1'b0;
					end
				end
				default: begin
					ack_st_q <= ACK_IDLE;
					ack_q    <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [1:0] txen_sync_q;
	logic [1:0] sysref_sync_q;
	logic       txen_prev_q;
	logic       sysref_prev_q;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			txen_sync_q   <= '0;
			sysref_sync_q <= '0;
			txen_prev_q   <= 1'b0;
			sysref_prev_q <= 1'b0;
		end else begin
			txen_sync_q   <= {txen_sync_q[0], tx_enable_pin};
			sysref_sync_q <= {sysref_sync_q[0], sysref};
			txen_prev_q   <= txen_sync_q[1];
			sysref_prev_q <= sysref_sync_q[1];
		end
	end

	wire txen       = txen_sync_q[1];
	wire txen_rise  = txen && !txen_prev_q;
	wire sysref_hit = sysref_sync_q[1] && !sysref_prev_q;

	// ****************************************
	// Carrier oscillator accumulator
	// ****************************************
	wire [1:0] fmode     = fm_q[FM_LO +: 2];
	// Register source: commit resets only in mode 01
	wire reg_src_rst = !txg_q[TXG_RST_PIN] && commit && fmode == FM_RESET_ACC;
	wire pin_src_rst = txg_q[TXG_RST_PIN] && txen_rise;
	wire acc_clear   = reg_src_rst || pin_src_rst || sysref_hit;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			phase_acc <= '0;
		end else if (acc_clear) begin
			phase_acc <= '0;
		end else begin
			phase_acc <= phase_acc + tw_q;
		end
	end

	// ****************************************
	// Full-scale current ramp
	// ****************************************
	// One step per cycle; minimum code stands for the 20 dB floor
	always_ff @(posedge clk) begin
		if (!resetn) begin
			fs_current <= 4'(FS_STEPS - 1);
		end else if (txg_q[TXG_FS_PIN] && !txen && fs_current != 4'h0) begin
			fs_current <= fs_current - 4'h1;
		end else if ((!txg_q[TXG_FS_PIN] || txen) && fs_current != 4'hf) begin
			fs_current <= fs_current + 4'h1;
		end
	end

	// ****************************************
	// Datapath: input gate, FIFO, droop FIR, output gate
	// ****************************************
	wire dp_pass  = txg_q[TXG_DP_PIN] ? txen : txg_q[TXG_DP_PASS];
	wire dac_pass = txg_q[TXG_DAC_PIN] ? txen : txg_q[TXG_DAC_PASS];

	logic        f_valid;
	logic        f_ready;
	logic [15:0] f_data;

	sample_fifo #(
		.WIDTH (16),
		.DEPTH (32)
	) u_fifo (
		.clk       (clk),
		.resetn    (resetn),
		.in_valid  (in_valid),
		.in_ready  (in_ready),
		.in_data   (dp_pass ? in_sample.sample : 16'h0000),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data)
	);

	// Symmetric seven taps; sum of -2+4+(-12)+24 = 14 over a shift of 5 gives a net loss for edge boost
	logic signed [15:0] tap_q [7];
	logic signed [21:0] fir_sum;

	assign droop_active = dp_q[DP_DROOP_EN];

	always_comb begin
		fir_sum = 22'(tap_q[3]) * 22'sd24
			- (22'(tap_q[2]) + 22'(tap_q[4])) * 22'sd6
			+ (22'(tap_q[1]) + 22'(tap_q[5])) * 22'sd2
			- (22'(tap_q[0]) + 22'(tap_q[6]));
	end

	wire out_free = !dac_valid || dac_ready;
	assign f_ready = out_free;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			for (int i = 0; i < 7; i++) begin
				tap_q[i] <= '0;
			end
		end else if (f_valid && f_ready) begin
			tap_q[0] <= f_data;
			for (int i = 1; i < 7; i++) begin
				tap_q[i] <= tap_q[i-1];
			end
		end
	end

	// Filter shift takes effect with the same handshake that loads the output
	wire [15:0] filt = 16'(fir_sum >>> 5);
	wire [15:0] path = droop_active ? filt : f_data;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			dac_valid  <= 1'b0;
			dac_sample <= '0;
		end else if (out_free) begin
			dac_valid <= f_valid;
			if (f_valid) begin
				dac_sample.sample <= (link_fault || !dac_pass) ? 16'h0000 : path;
			end
		end
	end

	// ****************************************
	// Register read-back
	// ****************************************
	always_comb begin
		case (reg_req.addr)
			ADDR_TX_GATING: reg_rdata = txg_q;
			ADDR_DP_CFG:    reg_rdata = dp_q;
			ADDR_TW_LOAD:   reg_rdata = {twl_q[7:2], ack_q, twl_q[0]};
			ADDR_FREQ_MODE: reg_rdata = fm_q;
			default: begin
				if (tw_byte_wr || (reg_req.addr >= ADDR_TW_BYTE0
						&& reg_req.addr <= ADDR_TW_BYTE5)) begin
					reg_rdata = stage_q[8*byte_idx(reg_req.addr) +: 8];
				end else begin
					reg_rdata = 8'h00;
				end
			end
		endcase
	end
endmodule

/* File: dv/nco_gate_monitor.sv */
`timescale 1ns/1ps
module nco_gate_monitor
	import nco_gate_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Register port and pins
	input  reg_req_t         reg_req,
	input  wire logic [7:0]  reg_rdata,
	input  wire logic        tx_enable_pin,
	input  wire logic        sysref,
	input  wire logic        link_fault,
	// Outputs
	input  wire logic        dac_valid,
	input  wire logic        dac_ready,
	input  sample_t          dac_sample,
	input  wire logic [47:0] phase_acc,
	input  wire logic [3:0]  fs_current,
	input  wire logic        droop_active
);
	logic       wr;
	logic       commit;
	logic [7:0] ld_q;
	logic [3:0] quiet_q;
	assign wr = reg_req.valid && reg_req.write;
	assign commit = wr && ((reg_req.addr == ADDR_TW_LOAD && ld_q[6:4] == SEL_MANUAL
		&& reg_req.wdata[0] && !ld_q[0]) || (ld_q[6:4] != SEL_MANUAL && ld_q[6:4] != 3'h7
		&& reg_req.addr == ADDR_TW_BYTE0 + 12'(ld_q[6:4]) - 12'h001));
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ld_q <= TW_RESET;
		end else if (wr && reg_req.addr == ADDR_TW_LOAD) begin
			ld_q <= reg_req.wdata;
		end
	end
	// Steps trusted only once synchronisers have settled
	always_ff @(posedge clk) begin
		if (!resetn || wr || sysref || $changed(tx_enable_pin)) begin
			quiet_q <= 4'h0;
		end else if (quiet_q != 4'hf) begin
			quiet_q <= quiet_q + 4'h1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence new_load;
		dac_valid && (!$past(dac_valid) || $past(dac_ready));
	endsequence
	gate_rsvd_a: assert property (reg_req.addr == ADDR_TX_GATING |-> reg_rdata[5:4] == 2'b00)
		else $error("gating reserved bits not zero");
	load_rsvd_a: assert property (reg_req.addr == ADDR_TW_LOAD |-> reg_rdata[7] == 1'b0
		&& reg_rdata[3:2] == 2'b00) else $error("load control reserved bits not zero");
	droop_read_a: assert property (reg_req.addr == ADDR_DP_CFG |-> reg_rdata[7] == droop_active)
		else $error("droop enable differs from register");
	reset_vals_a: assert property ($rose(resetn) |-> !droop_active && fs_current == 4'hf
		&& phase_acc == 48'h0 && !dac_valid) else $error("bad values after reset");
	fault_zero_a: assert property (new_load and $past(link_fault) && $past(link_fault, 2)
		&& $past(link_fault, 3) |-> dac_sample.sample == 16'h0000) else $error("fault data not zero");
	fs_step_a: assert property (fs_current == $past(fs_current) || fs_current == $past(fs_current)
		+ 4'h1 || fs_current == $past(fs_current) - 4'h1) else $error("current jumped");
	acc_step_a: assert property (quiet_q >= 4'ha |-> phase_acc - $past(phase_acc)
		== $past(phase_acc) - $past(phase_acc, 2)) else $error("accumulator step changed");
	load_ack_a: assert property (commit |-> ##2 (reg_req.addr != ADDR_TW_LOAD
		|| reg_rdata[TW_LOAD_ACK])) else $error("acknowledge missing after commit");
	commit_c: cover property (commit);
	fault_c: cover property (new_load and link_fault);
	fs_min_c: cover property (fs_current == 4'h0);
endmodule

/* File: dv/host_model.sv */
`timescale 1ns/1ps
module host_model
	import nco_gate_pkg::*;
(
	// Clock
	input  wire logic       clk,
	// Register port and pin
	output reg_req_t        req,
	input  wire logic [7:0] rdata,
	output logic            pin
);
	initial begin
		req = '0;
		pin = 1'b1;
	end
	// Address stays after a write so status can still be seen
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{valid: 1'b1, write: 1'b1, addr: a, wdata: d};
		@(posedge clk);
		req.valid <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [7:0] v);
		@(posedge clk);
		req <= '{valid: 1'b0, write: 1'b0, addr: a, wdata: 8'h00};
		@(posedge clk);
		v = rdata;
	endtask
	task automatic set_pin(input logic v);
		@(posedge clk);
		pin <= v;
	endtask
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/1ps
module testbench
	import nco_gate_pkg::*;
;
	logic        clk = 1'b0;
	logic        resetn, tx_enable_pin, sysref, link_fault, in_valid, in_ready;
	logic        dac_valid, dac_ready, droop_active, hold_q;
	reg_req_t    reg_req;
	logic [7:0]  reg_rdata;
	sample_t     in_sample, dac_sample;
	logic [47:0] phase_acc;
	logic [3:0]  fs_current;
	logic [31:0] rs = 32'h00000032;
	logic [15:0] exp_q [$];
	int          hist [$] = '{0, 0, 0, 0, 0, 0, 0};
	logic        fir_on = 1'b0;
	int          checks, mismatches, cyc;
	logic [11:0] ra [5] = '{ADDR_TX_GATING, ADDR_DP_CFG, ADDR_TW_LOAD, ADDR_FREQ_MODE, 12'h0ff};
	logic [7:0]  rv [5] = '{TXG_RESET, DP_RESET, TW_RESET, FM_RESET, 8'h00};
	logic [7:0]  gv [6] = '{8'hc0, 8'h40, 8'h80, 8'hc4, 8'hc2, 8'hc0};
	logic        gp [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
	logic        gl [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
	logic        gz [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
	localparam logic [47:0] tw1 = 48'h0a0b0c0d0e0f;
	host_model u_host (.clk(clk), .req(reg_req), .rdata(reg_rdata), .pin(tx_enable_pin));
	nco_update_and_tx_gating u_nco_update_and_tx_gating (.clk(clk), .resetn(resetn),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .tx_enable_pin(tx_enable_pin),
		.sysref(sysref), .link_fault(link_fault), .in_valid(in_valid), .in_ready(in_ready),
		.in_sample(in_sample), .dac_valid(dac_valid), .dac_ready(dac_ready),
		.dac_sample(dac_sample), .phase_acc(phase_acc), .fs_current(fs_current),
		.droop_active(droop_active));
	// ****
	// Helpers
	// ****
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	// Seven-tap droop model over the samples taken before this one
	function automatic logic [15:0] fir_model(input logic [15:0] s);
		int acc;
		acc = 24 * hist[3] - 6 * (hist[2] + hist[4]) + 2 * (hist[1] + hist[5])
			- (hist[0] + hist[6]);
		hist.push_front(int'($signed(s)));
		void'(hist.pop_back());
		return 16'(acc >>> 5);
	endfunction
	task automatic check(input logic [47:0] got, input logic [47:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic send(input int n, input logic z);
		logic [15:0] s;
		for (int i = 0; i < n; i++) begin
			s = 16'(xs());
			in_valid <= 1'b1;
			in_sample <= s;
			do @(posedge clk); while (in_ready !== 1'b1);
			exp_q.push_back(z ? 16'h0000 : (fir_on ? fir_model(s) : s));
		end
		in_valid <= 1'b0;
	endtask
	task automatic drain();
		for (int i = 0; i < 500 && exp_q.size() != 0; i++) @(posedge clk);
		repeat (3) @(posedge clk);
	endtask
	task automatic step(input logic [47:0] w);
		logic [47:0] a;
		@(posedge clk);
		a = phase_acc;
		@(posedge clk);
		check(phase_acc - a, w);
	endtask
	// Accumulator restarted: a small multiple of the word
	task automatic near_zero(input logic [47:0] w);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k <= 10; k++) if (phase_acc === w * 48'(k)) hit = 1'b1;
		check(48'(hit), 48'h1);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ****
	// Clock, sink, timeout
	// ****
	always #10 clk = ~clk;
	always @(posedge clk) begin
		if (resetn && dac_valid === 1'b1 && dac_ready) begin
			if (exp_q.size() == 0) check(48'(dac_sample), 48'hdead);
			else check(48'(dac_sample), 48'(exp_q.pop_front()));
		end
		dac_ready <= !hold_q && xs() > 32'h60000000;
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			report_and_stop();
		end
	end
	initial begin
		logic [7:0] v;
		{resetn, sysref, link_fault, in_valid, hold_q} = '0;
		in_sample = '0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			u_host.rd(ra[i], v);
			check(48'(v), 48'(rv[i]));
		end
		u_host.wr(ADDR_TX_GATING, 8'hff);
		u_host.rd(ADDR_TX_GATING, v);
		check(48'(v), 48'(TXG_WMASK));
		u_host.wr(ADDR_DP_CFG, 8'h80);
		u_host.rd(ADDR_DP_CFG, v);
		check(48'({v[DP_DROOP_EN], droop_active}), 48'h3);
		u_host.wr(ADDR_DP_CFG, DP_RESET);
		u_host.wr(ADDR_TX_GATING, TXG_RESET);
		$display("test registers done");
		hold_q <= 1'b1;
		send(33, 1'b0);
		repeat (2) @(posedge clk);
		check(48'(in_ready), 48'h0);
		hold_q <= 1'b0;
		drain();
		$display("test fifo done");
		for (int i = 0; i < 6; i++) begin
			u_host.wr(ADDR_TX_GATING, gv[i]);
			u_host.set_pin(gp[i]);
			link_fault <= gl[i];
			repeat (4) @(posedge clk);
			send(8, gz[i]);
			drain();
		end
		link_fault <= 1'b0;
		u_host.wr(ADDR_TX_GATING, 8'h80);
		send(8, 1'b1);
		drain();
		u_host.wr(ADDR_TX_GATING, TXG_RESET);
		u_host.wr(ADDR_DP_CFG, 8'h80);
		fir_on = 1'b1;
		send(16, 1'b0);
		drain();
		fir_on = 1'b0;
		u_host.wr(ADDR_DP_CFG, DP_RESET);
		$display("test gating done");
		for (int i = 0; i < 6; i++) u_host.wr(ADDR_TW_BYTE0 + 12'(i), tw1[8*i +: 8]);
		check(phase_acc, 48'h0);
		u_host.wr(ADDR_TW_LOAD, 8'h01);
		u_host.rd(ADDR_TW_LOAD, v);
		check(48'(v[TW_LOAD_ACK]), 48'h1);
		step(tw1);
		u_host.wr(ADDR_TW_LOAD, 8'h00);
		u_host.wr(ADDR_TW_LOAD, 8'h60);
		u_host.wr(ADDR_TW_BYTE5, 8'h20);
		repeat (COMMIT_CYCLES - 2) @(posedge clk);
		step({8'h20, tw1[39:0]});
		u_host.wr(ADDR_FREQ_MODE, 8'h40);
		u_host.wr(ADDR_TW_BYTE5, 8'h30);
		repeat (2) @(posedge clk);
		near_zero({8'h30, tw1[39:0]});
		repeat (20) @(posedge clk);
		sysref <= 1'b1;
		@(posedge clk);
		sysref <= 1'b0;
		repeat (6) @(posedge clk);
		near_zero({8'h30, tw1[39:0]});
		u_host.wr(ADDR_TX_GATING, 8'hc8);
		u_host.set_pin(1'b0);
		repeat (20) @(posedge clk);
		u_host.set_pin(1'b1);
		repeat (6) @(posedge clk);
		near_zero({8'h30, tw1[39:0]});
		$display("test oscillator done");
		u_host.wr(ADDR_TX_GATING, 8'hc1);
		check(48'(fs_current), 48'hf);
		u_host.set_pin(1'b0);
		repeat (24) @(posedge clk);
		check(48'(fs_current), 48'h0);
		u_host.set_pin(1'b1);
		repeat (24) @(posedge clk);
		check(48'(fs_current), 48'hf);
		$display("test current done");
		report_and_stop();
	end
endmodule
bind nco_update_and_tx_gating nco_gate_monitor u_mon (.clk(clk), .resetn(resetn),
	.reg_req(reg_req), .reg_rdata(reg_rdata), .tx_enable_pin(tx_enable_pin), .sysref(sysref),
	.link_fault(link_fault), .dac_valid(dac_valid), .dac_ready(dac_ready),
	.dac_sample(dac_sample), .phase_acc(phase_acc), .fs_current(fs_current),
	.droop_active(droop_active));
